// ### mswc_bank.sv
// Purpose: Mode, supply and watchdog control register bank
// Assumes: Chip core supplies restart, temperature and failure events
// Notes: Rules carried by this bank
// Behaviour
// R1: mode field selects normal, sleep, stop, reset
// R2: stop to sleep write refused
// R3: restart entry forces normal mode
// R4: restart or overtemperature turns second regulator off
// R5: bit5 enables third regulator
// R6: second regulator field encodes off and three on modes
// R7: overvoltage action only when bit2 set
// R8: bits1:0 select reset threshold
// R9: write reply shows previous contents
// R10: soft reset pulls reset pin unless skipped
// R11: force bit drives failure outputs
// R12: force clear keeps event failure outputs
// R13: restart clears force bit; event failure outputs kept
// R14: soft reset keeps voltage select, load share
// R15: uv keep bit controls third regulator shutdown
// R16: load share, stop share, voltage select bits
// R17: trigger select picks first or second failure
// R18: controller writes even parity checksum
// R19: bit5 selects window or timeout watchdog
// R20: bus wake start bit starts watchdog
// R21: period field encodes 10 to 500 ms
// R22: bit6 disables watchdog in stop
// R23: frame is write bit, address, data
// R24: reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module mswc_bank
    import mswc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // SPI pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    // Core events
    input wire mswc_evt_t coreEvt,
    input wire logic mainOvEvent,
    input wire logic supplyUv,
    // Settings and outputs
    output mswc_cfg_t cfgOut,
    output logic softResetReq,
    output logic resetPinLow,
    output logic failureOutput,
    output logic mainOvFlag,
    output logic mainOvRestartReq,
    output logic thirdRegOn,
    output logic checksumOk
);
    // Register storage
    logic [7:0] modeSupply_ff;
    logic [7:0] hwConfig_ff;
    logic [7:0] wdConfig_ff;
    // Failure output latched by a failure event
    logic failLatch_ff;
    // Shifter wires
    logic addrValid;
    logic [7:0] addrByte;
    logic frameDone;
    logic [15:0] frameWord;
    logic [7:0] replyByte;
    logic misoBit;
    logic isWrite;
    logic [6:0] frameAddr;
    logic [7:0] wrData;
    logic doSoft;

    // Read mux used for the reply byte only
    function automatic logic [7:0] readReg(input logic [6:0] a, input logic [7:0] ms,
                                           input logic [7:0] hw, input logic [7:0] wd);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            ADDR_MODE_SUPPLY: r = ms;
            ADDR_HW_CONFIG: r = hw & HW_CONFIG_WMASK; // [R24]
            ADDR_WD_CONFIG: r = wd & WD_CONFIG_WMASK; // [R24]
            default: r = 8'h00;
        endcase
        return r;
    endfunction : readReg

    // Frame shifter
    mswc_spi_shift u_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .spiSck(spiSck),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .replyByte(replyByte),
        .addrValid(addrValid),
        .addrByte(addrByte),
        .frameDone(frameDone),
        .frameWord(frameWord),
        .misoBit(misoBit)
    );

    // Reply is contents before this frame's write lands
    assign replyByte = readReg(addrByte[6:0], modeSupply_ff, hwConfig_ff, wdConfig_ff); // [R9]
    // Write bit then address field then data byte
    assign frameAddr = frameWord[14:8]; // [R23]
    assign isWrite = frameWord[15]; // [R23]
    assign wrData = frameWord[7:0];
    assign doSoft = frameDone && isWrite && (frameAddr == ADDR_MODE_SUPPLY)
        && (wrData[MODE_MSB:MODE_LSB] == MSWC_SOFTRST); // [R1]

    // Mode and supply register
    always_ff @(posedge sys_clk) begin
        if (rst || doSoft) begin
            modeSupply_ff <= MODE_SUPPLY_POR;
        end else if (coreEvt.restartEntry) begin
            // Hardware event wins over a write in the same cycle, except a soft reset write
            modeSupply_ff <= (modeSupply_ff & MS_RESTART_KEEP); // [R3] [R4]
        end else begin
            if (frameDone && isWrite && frameAddr == ADDR_MODE_SUPPLY) begin
                modeSupply_ff <= wrData;
                // Stop to sleep is not taken; mode stays stop
                if (modeSupply_ff[MODE_MSB:MODE_LSB] == MSWC_STOP
                    && wrData[MODE_MSB:MODE_LSB] == MSWC_SLEEP) begin
                    modeSupply_ff[MODE_MSB:MODE_LSB] <= MSWC_STOP; // [R2]
                end
                if (coreEvt.overTemp) begin
                    modeSupply_ff[SECOND_MSB:SECOND_LSB] <= SECOND_OFF; // [R4]
                end
            end else if (coreEvt.overTemp) begin
                modeSupply_ff[SECOND_MSB:SECOND_LSB] <= SECOND_OFF; // [R4]
            end
        end
    end

    // Hardware configuration register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hwConfig_ff <= HW_CONFIG_POR;
        end else if (doSoft) begin
            hwConfig_ff <= hwConfig_ff & HW_SOFT_KEEP; // [R14]
        end else if (coreEvt.restartEntry) begin
            hwConfig_ff <= hwConfig_ff & HW_RESTART_KEEP; // [R13]
        end else if (frameDone && isWrite && frameAddr == ADDR_HW_CONFIG) begin
            hwConfig_ff <= wrData & HW_CONFIG_WMASK; // [R24]
        end
    end

    // Watchdog configuration register; core may load period and stop bit
    always_ff @(posedge sys_clk) begin
        if (rst || doSoft) begin
            wdConfig_ff <= WD_CONFIG_POR;
        end else if (coreEvt.restartEntry) begin
            wdConfig_ff <= (wdConfig_ff & WD_RESTART_KEEP) | WD_RESTART_SET;
        end else begin
            if (frameDone && isWrite && frameAddr == ADDR_WD_CONFIG) begin
                wdConfig_ff <= wrData & WD_CONFIG_WMASK;
            end
            // Hardware updates after the write so they win
            if (coreEvt.wdTimerLoad) begin
                wdConfig_ff[2:0] <= coreEvt.wdTimerValue;
            end
            if (coreEvt.wdStopLoad) begin
                wdConfig_ff[WD_STOP_BIT] <= coreEvt.wdStopValue;
            end
        end
    end

    // Failure output latch from events; flag clear or soft reset releases it
    always_ff @(posedge sys_clk) begin
        if (rst || doSoft) begin
            failLatch_ff <= 1'b0;
        end else if (coreEvt.failureEvent) begin
            failLatch_ff <= 1'b1; // [R12]
        end else if (coreEvt.failureFlagClear) begin
            failLatch_ff <= 1'b0; // [R12]
        end
    end

    // Overvoltage flag always set; action gated by configuration
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mainOvFlag <= 1'b0;
            mainOvRestartReq <= 1'b0;
        end else begin
            if (mainOvEvent) begin
                mainOvFlag <= 1'b1; // [R7]
            end else if (frameDone && !isWrite && frameAddr == ADDR_MODE_SUPPLY) begin
                // Flag is read-to-clear by convention here
                mainOvFlag <= 1'b0;
            end
            mainOvRestartReq <= mainOvEvent && modeSupply_ff[OV_ACTION_BIT]; // [R7]
        end
    end

    // Soft reset request and reset pin
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softResetReq <= 1'b0;
            resetPinLow <= 1'b0;
        end else begin
            softResetReq <= doSoft; // [R1]
            if (doSoft) begin
                resetPinLow <= ~hwConfig_ff[SOFT_SKIP_BIT]; // [R10]
            end else if (coreEvt.softResetDone) begin
                resetPinLow <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spiMiso <= 1'b0;
            failureOutput <= 1'b0;
            thirdRegOn <= 1'b0;
            checksumOk <= 1'b1;
        end else begin
            spiMiso <= misoBit;
            // Force bit or event latch drive the failure output
            failureOutput <= hwConfig_ff[FO_FORCE_BIT] | failLatch_ff; // [R11] [R13]
            // Third regulator drops at undervoltage unless kept
            thirdRegOn <= modeSupply_ff[THIRD_EN_BIT]
                && (hwConfig_ff[UV_KEEP_BIT] || !supplyUv); // [R5] [R15]
            // Even parity over the watchdog configuration register
            checksumOk <= ~^wdConfig_ff; // [R18]
        end
    end

    // Decoded settings bus
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfgOut <= '0;
        end else begin
            cfgOut.mode <= modeSupply_ff[MODE_MSB:MODE_LSB]; // [R1]
            cfgOut.thirdEnable <= modeSupply_ff[THIRD_EN_BIT]; // [R5]
            cfgOut.secondMode <= modeSupply_ff[SECOND_MSB:SECOND_LSB]; // [R6]
            cfgOut.ovAction <= modeSupply_ff[OV_ACTION_BIT];
            cfgOut.resetThreshold <= modeSupply_ff[1:0]; // [R8]
            cfgOut.voltSelect <= hwConfig_ff[VOLT_SEL_BIT]; // [R16]
            cfgOut.softResetSkip <= hwConfig_ff[SOFT_SKIP_BIT];
            cfgOut.foForce <= hwConfig_ff[FO_FORCE_BIT];
            cfgOut.uvKeep <= hwConfig_ff[UV_KEEP_BIT];
            cfgOut.loadShare <= hwConfig_ff[LOAD_SHARE_BIT]; // [R16]
            cfgOut.lsStopEnable <= hwConfig_ff[LS_STOP_BIT]; // [R16]
            cfgOut.trigSelect <= hwConfig_ff[TRIG_SEL_BIT]; // [R17]
            cfgOut.wdStopDisable <= wdConfig_ff[WD_STOP_BIT]; // [R22]
            cfgOut.wdWindow <= wdConfig_ff[WATCHDOG_WINDOW_SELECT_BIT]; // [R19]
            cfgOut.wdBusWake <= wdConfig_ff[WD_WAKE_BIT]; // [R20]
            cfgOut.wdPeriod <= wdConfig_ff[2:0]; // [R21]
        end
    end
endmodule : mswc_bank
`default_nettype wire

// ### mswc_bank_monitor.sv
// Purpose: Port assertions for the mode, supply and watchdog bank
// Assumes: cfgOut and level outputs follow a register change within a clock or two
// Notes: Bound onto every mswc_bank instance
`timescale 1ns/1ps
`default_nettype none
module mswc_bank_monitor
    import mswc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched inputs
    input wire mswc_evt_t coreEvt,
    input wire logic mainOvEvent,
    input wire logic supplyUv,
    // Watched outputs
    input wire mswc_cfg_t cfgOut,
    input wire logic softResetReq,
    input wire logic resetPinLow,
    input wire logic failureOutput,
    input wire logic mainOvFlag,
    input wire logic mainOvRestartReq,
    input wire logic thirdRegOn
);
    // One domain, so one clocking and one disable
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Contents left by a soft reset
    sequence softCleared;
        cfgOut.mode == MSWC_NORMAL && cfgOut.wdPeriod == 3'h4 && cfgOut.wdBusWake && !cfgOut.foForce;
    endsequence
    // Contents forced by restart entry
    sequence restartForced;
        cfgOut.mode == MSWC_NORMAL && cfgOut.secondMode == SECOND_OFF && !cfgOut.foForce;
    endsequence
    ov_flag_set_a: assert property (mainOvEvent |=> mainOvFlag)
        else $error("overvoltage flag not set");
    ov_req_cause_a: assert property (mainOvRestartReq |-> $past(mainOvEvent) && cfgOut.ovAction)
        else $error("restart request without enabled overvoltage");
    restart_clear_a: assert property (coreEvt.restartEntry |=> ##[0:2] restartForced)
        else $error("restart entry did not force settings");
    overtemp_off_a: assert property (coreEvt.overTemp |=> ##[0:2] cfgOut.secondMode == SECOND_OFF)
        else $error("overtemperature left second regulator on");
    soft_defaults_a: assert property (softResetReq |=> ##[0:2] softCleared)
        else $error("soft reset values wrong");
    force_output_a: assert property (cfgOut.foForce [*3] |-> failureOutput)
        else $error("forced failure output inactive");
    fail_event_a: assert property (coreEvt.failureEvent |=> ##[0:1] failureOutput)
        else $error("failure event did not drive output");
    pin_cause_a: assert property ($rose(resetPinLow) |-> softResetReq || $past(softResetReq))
        else $error("reset pin pulled without soft reset");
    pin_release_a: assert property (resetPinLow && coreEvt.softResetDone && !softResetReq |=> !resetPinLow)
        else $error("reset pin not released");
    uv_third_off_a: assert property ((supplyUv && !cfgOut.uvKeep) [*3] |-> !thirdRegOn)
        else $error("third regulator on at undervoltage");
    third_disable_a: assert property ((!cfgOut.thirdEnable) [*3] |-> !thirdRegOn)
        else $error("third regulator on while disabled");
    stop_sleep_a: assert property (cfgOut.mode == MSWC_STOP |=> cfgOut.mode != MSWC_SLEEP)
        else $error("stop went straight to sleep");
    // Overvoltage restart path reached
    cover property (mainOvRestartReq);
endmodule : mswc_bank_monitor
bind mswc_bank mswc_bank_monitor i_mswc_bank_monitor (.sys_clk, .rst, .coreEvt, .mainOvEvent, .supplyUv,
    .cfgOut, .softResetReq, .resetPinLow, .failureOutput, .mainOvFlag, .mainOvRestartReq, .thirdRegOn);
`default_nettype wire

// ### mswc_bank_tb.sv
// Purpose: Self-checking bench for the mode, supply and watchdog bank
// Assumes: Register update and decode settle within the frame gap
// Notes: Inputs change on falling sys_clk edges
`timescale 1ns/1ps
`default_nettype none
module mswc_bank_tb;
    import mswc_pkg::*;
    // Clock, reset and core stimulus
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    mswc_evt_t coreEvt = '0;
    logic mainOvEvent = 1'b0;
    logic supplyUv = 1'b0;
    // Pins and outputs
    wire logic spiSck, spiCsN, spiMosi, spiMiso;
    mswc_cfg_t cfgOut;
    logic softResetReq, resetPinLow, failureOutput, mainOvFlag, mainOvRestartReq, thirdRegOn, checksumOk;
    // Bookkeeping
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic [7:0] d;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    mswc_spi_master i_mswc_spi_master (.sys_clk(sys_clk), .spiSck(spiSck), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso));
    mswc_bank i_mswc_bank (.sys_clk(sys_clk), .rst(rst), .spiSck(spiSck), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .coreEvt(coreEvt), .mainOvEvent(mainOvEvent),
        .supplyUv(supplyUv), .cfgOut(cfgOut), .softResetReq(softResetReq), .resetPinLow(resetPinLow),
        .failureOutput(failureOutput), .mainOvFlag(mainOvFlag), .mainOvRestartReq(mainOvRestartReq),
        .thirdRegOn(thirdRegOn), .checksumOk(checksumOk));

    // Verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Hang guard, far above the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            close_out();
        end
    end
    // Compare one value
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Register write; rd gets the reply byte
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        i_mswc_spi_master.xfer({1'b1, a, v}, rd);
    endtask : wr
    // Register read into rd
    task automatic rdr(input logic [6:0] a);
        i_mswc_spi_master.xfer({1'b0, a, 8'h00}, rd);
    endtask : rdr
    // One-cycle core event pulse
    task automatic evt(input mswc_evt_t e);
        @(negedge sys_clk);
        coreEvt = e;
        @(negedge sys_clk);
        coreEvt = '0;
        repeat (4) @(negedge sys_clk);
    endtask : evt
    // Power-on values and unmapped space
    task automatic t_reset();
        rdr(ADDR_MODE_SUPPLY);
        check("ms por", rd, 8'h00);
        rdr(ADDR_HW_CONFIG);
        check("hw por", rd, 8'h00);
        rdr(ADDR_WD_CONFIG);
        check("wd por", rd, 8'h14);
        check("sum por", checksumOk, 1'b1);
        rdr(7'h7F);
        check("unmapped", rd, 8'h00);
    endtask : t_reset
    // Reply shows old contents; supply fields decode
    task automatic t_supply();
        wr(ADDR_MODE_SUPPLY, 8'h1D);
        wr(ADDR_MODE_SUPPLY, 8'h2A);
        check("write reply", rd, 8'h1D);
        check("second", cfgOut.secondMode, 2'h1);
        check("thresh", cfgOut.resetThreshold, 2'h2);
        check("third on", thirdRegOn, 1'b1);
        @(negedge sys_clk);
        supplyUv = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("uv off", thirdRegOn, 1'b0);
        wr(ADDR_HW_CONFIG, 8'h10);
        check("uv keep", thirdRegOn, 1'b1);
        supplyUv = 1'b0;
    endtask : t_supply
    // Reserved bits and watchdog fields
    task automatic t_reserved();
        wr(ADDR_HW_CONFIG, 8'hFF);
        wr(ADDR_HW_CONFIG, 8'h00);
        check("hw rsvd", rd, 8'hFB);
        wr(ADDR_WD_CONFIG, 8'hFF);
        check("odd sum", checksumOk, 1'b0);
        check("wd bits", {cfgOut.wdStopDisable, cfgOut.wdWindow, cfgOut.wdBusWake}, 3'h7);
        // Period codes 0 to 5, checksum kept even
        for (int p = 0; p < 6; p++) begin
            d = {^{1'b1, p[2:0]}, 4'h2, p[2:0]};
            wr(ADDR_WD_CONFIG, d);
            check("period", cfgOut.wdPeriod, p[2:0]);
            check("even sum", checksumOk, 1'b1);
            // First loop write returns the masked all-ones word
            if (p == 0) begin
                check("wd rsvd", rd, 8'hF7);
            end
        end
    endtask : t_reserved
    // Stop to sleep refused, slow SCK
    task automatic t_stop_sleep();
        i_mswc_spi_master.halfCyc = 8;
        wr(ADDR_MODE_SUPPLY, 8'h80);
        wr(ADDR_MODE_SUPPLY, 8'h40);
        rdr(ADDR_MODE_SUPPLY);
        check("stop kept", rd, 8'h80);
        wr(ADDR_MODE_SUPPLY, 8'h00);
        wr(ADDR_MODE_SUPPLY, 8'h40);
        check("sleep", cfgOut.mode, MSWC_SLEEP);
        wr(ADDR_MODE_SUPPLY, 8'h00);
        i_mswc_spi_master.halfCyc = 4;
    endtask : t_stop_sleep
    // Soft reset with and without the reset pin
    task automatic t_soft();
        wr(ADDR_HW_CONFIG, 8'h8B);
        check("hw bits", {cfgOut.voltSelect, cfgOut.loadShare, cfgOut.lsStopEnable, cfgOut.trigSelect}, 4'hF);
        wr(ADDR_MODE_SUPPLY, 8'hC0);
        check("pin low", resetPinLow, 1'b1);
        rdr(ADDR_HW_CONFIG);
        check("hw soft", rd, 8'h88);
        rdr(ADDR_WD_CONFIG);
        check("wd soft", rd, 8'h14);
        evt(11'h100); // Soft reset done
        check("pin free", resetPinLow, 1'b0);
        wr(ADDR_HW_CONFIG, 8'hC8);
        wr(ADDR_MODE_SUPPLY, 8'hC0);
        check("pin skip", resetPinLow, 1'b0);
    endtask : t_soft
    // Restart and failure output handling
    task automatic t_restart();
        wr(ADDR_MODE_SUPPLY, 8'h1F);
        wr(ADDR_WD_CONFIG, 8'hF3);
        wr(ADDR_HW_CONFIG, 8'h20);
        check("forced", failureOutput, 1'b1);
        evt(11'h400); // Restart entry
        check("force off", failureOutput, 1'b0);
        rdr(ADDR_MODE_SUPPLY);
        check("ms rst", rd, 8'h03);
        rdr(ADDR_HW_CONFIG);
        check("hw rst", rd, 8'h00);
        evt(11'h080); // Failure event
        wr(ADDR_HW_CONFIG, 8'h20);
        wr(ADDR_HW_CONFIG, 8'h00);
        check("latched", failureOutput, 1'b1);
        evt(11'h040); // Failure flag cleared
        check("unlatched", failureOutput, 1'b0);
    endtask : t_restart
    // Overvoltage and overtemperature
    task automatic t_ov();
        wr(ADDR_MODE_SUPPLY, 8'h18);
        @(negedge sys_clk);
        mainOvEvent = 1'b1;
        @(negedge sys_clk);
        mainOvEvent = 1'b0;
        check("ov no req", mainOvRestartReq, 1'b0);
        @(negedge sys_clk);
        check("ov flag", mainOvFlag, 1'b1);
        wr(ADDR_MODE_SUPPLY, 8'h1C);
        @(negedge sys_clk);
        mainOvEvent = 1'b1;
        @(negedge sys_clk);
        mainOvEvent = 1'b0;
        check("ov req", mainOvRestartReq, 1'b1);
        evt(11'h200); // Overtemperature
        rdr(ADDR_MODE_SUPPLY);
        check("ot second", rd, 8'h04);
        evt(11'h037); // Core loads period 5 and stop bit
        check("core load", {cfgOut.wdStopDisable, cfgOut.wdPeriod}, 4'hD);
    endtask : t_ov
    // Main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_supply();
        t_reserved();
        t_stop_sleep();
        t_soft();
        t_restart();
        t_ov();
        close_out();
    end
endmodule : mswc_bank_tb
`default_nettype wire

// ### mswc_pkg.sv
// Purpose: Constants and types for the mode, supply and watchdog control bank
// Assumes: 16-bit SPI frames, address byte first, MSB first
// Notes: Offsets are register addresses carried in the SPI address field
package mswc_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_WD_CONFIG = 7'h03;
    // Power-on values
    localparam logic [7:0] MODE_SUPPLY_POR = 8'h00;
    localparam logic [7:0] HW_CONFIG_POR = 8'h00;
    localparam logic [7:0] WD_CONFIG_POR = 8'h14;
    // Writable masks (reserved bits cleared)
    localparam logic [7:0] HW_CONFIG_WMASK = 8'hFB;
    localparam logic [7:0] WD_CONFIG_WMASK = 8'hF7;
    // Soft reset keeps voltage select and load share
    localparam logic [7:0] HW_SOFT_KEEP = 8'h88;
    // Restart keep masks
    localparam logic [7:0] MS_RESTART_KEEP = 8'h23;
    localparam logic [7:0] HW_RESTART_KEEP = 8'hD9;
    localparam logic [7:0] WD_RESTART_KEEP = 8'hB0;
    localparam logic [7:0] WD_RESTART_SET = 8'h04;
    // Field positions
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int THIRD_EN_BIT = 5;
    localparam int SECOND_MSB = 4;
    localparam int SECOND_LSB = 3;
    localparam int OV_ACTION_BIT = 2;
    localparam int VOLT_SEL_BIT = 7;
    localparam int SOFT_SKIP_BIT = 6;
    localparam int FO_FORCE_BIT = 5;
    localparam int UV_KEEP_BIT = 4;
    localparam int LOAD_SHARE_BIT = 3;
    localparam int LS_STOP_BIT = 1;
    localparam int TRIG_SEL_BIT = 0;
    localparam int WD_STOP_BIT = 6;
    localparam int WATCHDOG_WINDOW_SELECT_BIT = 5;
    localparam int WD_WAKE_BIT = 4;
    // Frame
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LAST = 5'h0F;
    localparam logic [4:0] ADDR_LAST = 5'h07;

    // Operating modes
    typedef enum logic [1:0] {
        MSWC_NORMAL = 2'h0,
        MSWC_SLEEP = 2'h1,
        MSWC_STOP = 2'h2,
        MSWC_SOFTRST = 2'h3
    } mswc_mode_t;

    // Second regulator encodings
    localparam logic [1:0] SECOND_OFF = 2'h0;

    // Decoded settings presented to the rest of the chip
    typedef struct packed {
        logic [1:0] mode;
        logic thirdEnable;
        logic [1:0] secondMode;
        logic ovAction;
        logic [1:0] resetThreshold;
        logic voltSelect;
        logic softResetSkip;
        logic foForce;
        logic uvKeep;
        logic loadShare;
        logic lsStopEnable;
        logic trigSelect;
        logic wdStopDisable;
        logic wdWindow;
        logic wdBusWake;
        logic [2:0] wdPeriod;
    } mswc_cfg_t;

    // Hardware events from the chip core
    typedef struct packed {
        logic restartEntry;
        logic overTemp;
        logic softResetDone;
        logic failureEvent;
        logic failureFlagClear;
        logic wdTimerLoad;
        logic [2:0] wdTimerValue;
        logic wdStopLoad;
        logic wdStopValue;
    } mswc_evt_t;
endpackage : mswc_pkg

// ### mswc_spi_master.sv
// Purpose: Controller model driving 16-bit SPI frames, mode 0
// Assumes: Pins paced from sys_clk falling edges
// Notes: halfCyc sets prompt or slow SCK; SCK stands low between frames
`timescale 1ns/1ps
`default_nettype none
module mswc_spi_master (
    // Pacing clock
    input wire logic sys_clk,
    // SPI pins
    output logic spiSck,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso
);
    int halfCyc = 4; // Sys clocks per SCK half period
    // Idle pins
    initial begin
        spiSck = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // Write bit, address, then data byte, MSB first
    task automatic xfer(input logic [15:0] cmd, output logic [7:0] rsp);
        rsp = 8'h00;
        @(negedge sys_clk);
        spiCsN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiMosi = cmd[i];
            repeat (halfCyc) @(negedge sys_clk);
            spiSck = 1'b1;
            // Reply byte rides the data half
            if (i < 8) begin
                rsp = {rsp[6:0], spiMiso};
            end
            repeat (halfCyc) @(negedge sys_clk);
            spiSck = 1'b0;
        end
        repeat (halfCyc) @(negedge sys_clk);
        spiCsN = 1'b1;
        spiMosi = ~spiMosi; // Released line must not mimic held data
        repeat (12) @(negedge sys_clk);
    endtask : xfer
endmodule : mswc_spi_master
`default_nettype wire

// ### mswc_spi_shift.sv
// Purpose: SPI slave shifter for 16-bit frames
// Assumes: Mode 0, data sampled on rising SCK, changed on falling
// Notes: Pins pass two flops; SCK edges are found in sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module mswc_spi_shift
    import mswc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    // Reply byte loaded after address byte
    input wire logic [7:0] replyByte,
    // Decoded frame
    output logic addrValid,
    output logic [7:0] addrByte,
    output logic frameDone,
    output logic [15:0] frameWord,
    output logic misoBit
);
    // Synchroniser stages
    logic [1:0] sckSync_ff;
    logic [1:0] csSync_ff;
    logic [1:0] mosiSync_ff;
    logic sckLast_ff;
    logic [4:0] bitCnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] outShift_ff;
    logic rise;
    logic fall;

    // Two-flop capture of all pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sckSync_ff <= 2'h0;
            csSync_ff <= 2'h3;
            mosiSync_ff <= 2'h0;
            sckLast_ff <= 1'b0;
        end else begin
            sckSync_ff <= {sckSync_ff[0], spiSck};
            csSync_ff <= {csSync_ff[0], spiCsN};
            mosiSync_ff <= {mosiSync_ff[0], spiMosi};
            sckLast_ff <= sckSync_ff[1];
        end
    end

    assign rise = sckSync_ff[1] & ~sckLast_ff & ~csSync_ff[1];
    assign fall = ~sckSync_ff[1] & sckLast_ff & ~csSync_ff[1];

    // Input shift and frame count
    always_ff @(posedge sys_clk) begin
        if (rst || csSync_ff[1]) begin
            bitCnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
        end else if (rise) begin
            shift_ff <= {shift_ff[14:0], mosiSync_ff[1]};
            bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end

    // Address pulse after eighth bit, frame pulse after sixteenth
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addrValid <= 1'b0;
            frameDone <= 1'b0;
            addrByte <= 8'h00;
            frameWord <= 16'h0000;
        end else begin
            addrValid <= rise && (bitCnt_ff == ADDR_LAST);
            frameDone <= rise && (bitCnt_ff == FRAME_LAST);
            if (rise && (bitCnt_ff == ADDR_LAST)) begin
                addrByte <= {shift_ff[6:0], mosiSync_ff[1]};
            end
            if (rise && (bitCnt_ff == FRAME_LAST)) begin
                frameWord <= {shift_ff[14:0], mosiSync_ff[1]};
            end
        end
    end

    // Output shift; reply byte loaded once address is known
    always_ff @(posedge sys_clk) begin
        if (rst || csSync_ff[1]) begin
            outShift_ff <= 8'h00;
            misoBit <= 1'b0;
        end else if (addrValid) begin
            outShift_ff <= {replyByte[6:0], 1'b0};
            misoBit <= replyByte[7];
        end else if (fall && bitCnt_ff > ADDR_LAST + 5'h01) begin
            // Eighth fall must not shift: the top reply bit has to stand at the ninth rise
            misoBit <= outShift_ff[7];
            outShift_ff <= {outShift_ff[6:0], 1'b0};
        end
    end
endmodule : mswc_spi_shift
`default_nettype wire
